//--- cbx_addr_resolve.sv
// Resolves an 8-bit register operand into a 12-bit data address
`timescale 1ns/1ns
`include "cbx_regs.svh"
module cbx_addr_resolve (
  // Operand
  input wire logic acc,
  input wire logic [7:0] f,
  // Addressing context
  input wire logic [3:0] bank_selection_register,
  input wire logic ext_en,
  input wire logic [11:0] index_base,
  // Result
  output logic [11:0] addr
);
  always_comb begin
    if (acc) begin
      addr = {bank_selection_register, f}; // [RL7]
    end else if (ext_en && (f <= `CBX_INDEX_LIMIT)) begin
      addr = index_base + {4'h0, f}; // [RL8]
    end else if (f < `CBX_ACCESS_SPLIT) begin
      addr = {`CBX_ACCESS_LOW_BANK, f}; // [RL6]
    end else begin
      addr = {`CBX_ACCESS_HIGH_BANK, f}; // [RL6]
    end
  end
endmodule

//--- cbx_exec.sv
// Execution unit for branch on carry set and single register bit clear
`timescale 1ns/1ns
`include "cbx_regs.svh"
// Behaviour
// RL1 - Branch only on carry; else next instruction
// RL2 - Signed offset doubled and added to PC
// RL3 - Target is instruction address plus two plus 2n
// RL4 - Taken branch adds one all-idle cycle
// RL5 - Bit clear forces chosen register bit zero
// RL6 - Access flag zero selects access bank
// RL7 - Access flag one uses bank selection register
// RL8 - Extended set, low address: indexed literal offset
module cbx_exec #(
  parameter int PC_W = 21
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Instruction stream and core state
  input wire logic [15:0] INSTR,
  input wire logic CARRY,
  input wire logic EXT_EN,
  input wire logic [3:0] BSR_IN,
  input wire logic [11:0] INDEX_BASE,
  // Program counter and phase
  output logic [PC_W-1:0] PC_OUT,
  output logic [3:0] Q_PHASE,
  output logic NOP_CYCLE,
  // Data memory
  output logic [11:0] DMEM_ADDR,
  output logic DMEM_RD,
  input wire logic [7:0] DMEM_RDATA,
  output logic DMEM_WR,
  output logic [7:0] DMEM_WDATA
);
  cbx_pkg::cbx_phase_t phase_reg;
  cbx_pkg::cbx_dec_t dec_reg;
  cbx_pkg::cbx_dec_t dec_next;
  logic carry_reg;
  logic flush_reg;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] offset2;
  logic [11:0] addr_next;
  logic [11:0] addr_reg;
  logic rd_reg;
  logic wr_reg;
  logic [7:0] wdata_reg;
  logic taken;

  // Instruction decode
  always_comb begin
    dec_next = '0;
    dec_next.is_branch_on_carry_set =
      (INSTR[`CBX_OP_HI_POS:`CBX_BC_OP_LO_POS] == `CBX_BC_OPCODE);
    dec_next.is_clear_single_register_bit =
      (INSTR[`CBX_OP_HI_POS:`CBX_BCF_OP_LO_POS] == `CBX_BCF_OPCODE); // [RL5]
    dec_next.bit_idx = INSTR[`CBX_BIT_HI_POS:`CBX_BIT_LO_POS];
    dec_next.acc = INSTR[`CBX_ACC_POS];
    dec_next.lit = INSTR[`CBX_LIT_HI_POS:`CBX_LIT_LO_POS];
  end

  // Sign-extended doubled literal
  assign offset2 = PC_W'({{(PC_W-9){dec_reg.lit[7]}}, dec_reg.lit, 1'b0}); // [RL2]
  assign taken = dec_reg.is_branch_on_carry_set && carry_reg && !flush_reg; // [RL1]

  cbx_addr_resolve u_resolve (
    .acc(dec_reg.acc),
    .f(dec_reg.lit),
    .bank_selection_register(BSR_IN),
    .ext_en(EXT_EN),
    .index_base(INDEX_BASE),
    .addr(addr_next)
  );

  // Four-phase sequencer
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      phase_reg <= cbx_pkg::PH_Q1;
    end else begin
      unique case (phase_reg)
        cbx_pkg::PH_Q1: phase_reg <= cbx_pkg::PH_Q2;
        cbx_pkg::PH_Q2: phase_reg <= cbx_pkg::PH_Q3;
        cbx_pkg::PH_Q3: phase_reg <= cbx_pkg::PH_Q4;
        cbx_pkg::PH_Q4: phase_reg <= cbx_pkg::PH_Q1;
      endcase
    end
  end

  // Decode latch; a flushed cycle decodes nothing
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dec_reg <= '0;
      carry_reg <= 1'b0;
    end else if (phase_reg == cbx_pkg::PH_Q1) begin
      dec_reg <= flush_reg ? '0 : dec_next; // [RL4]
      carry_reg <= CARRY;
    end
  end

  // Refill cycle after a taken branch
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      flush_reg <= 1'b0;
    end else if (phase_reg == cbx_pkg::PH_Q4) begin
      flush_reg <= taken; // [RL4]
    end
  end

  // Program counter
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pc_reg <= PC_W'(`CBX_PC_RESET);
    end else if (phase_reg == cbx_pkg::PH_Q1 && !flush_reg) begin
      pc_reg <= pc_reg + PC_W'(`CBX_PC_STEP); // [RL3]
    end else if (phase_reg == cbx_pkg::PH_Q4 && taken) begin
      pc_reg <= pc_reg + offset2; // [RL2] [RL3]
    end
  end

  // Data address and read strobe
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      addr_reg <= `CBX_ADDR_RESET;
      rd_reg <= 1'b0;
    end else if (phase_reg == cbx_pkg::PH_Q2) begin
      rd_reg <= dec_reg.is_clear_single_register_bit;
      if (dec_reg.is_clear_single_register_bit) begin
        addr_reg <= addr_next; // [RL6] [RL7] [RL8]
      end
    end else begin
      rd_reg <= 1'b0;
    end
  end

  // Bit clear data path
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wdata_reg <= `CBX_DATA_RESET;
    end else if (rd_reg) begin
      wdata_reg <= DMEM_RDATA & ~(8'h01 << dec_reg.bit_idx); // [RL5]
    end
  end

  // Write strobe in Q4
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_reg <= 1'b0;
    end else begin
      wr_reg <= (phase_reg == cbx_pkg::PH_Q3) && dec_reg.is_clear_single_register_bit;
    end
  end

  assign PC_OUT = pc_reg;
  assign Q_PHASE = phase_reg;
  assign NOP_CYCLE = flush_reg;
  assign DMEM_ADDR = addr_reg;
  assign DMEM_RD = rd_reg;
  assign DMEM_WR = wr_reg;
  assign DMEM_WDATA = wdata_reg;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  phase_rotate_a: assert property ((phase_reg == cbx_pkg::PH_Q1) |=>
    (phase_reg == cbx_pkg::PH_Q2) ##1 (phase_reg == cbx_pkg::PH_Q3)
    ##1 (phase_reg == cbx_pkg::PH_Q4))
    else $error("phase sequence broken");

  branch_skip_a: assert property ((phase_reg == cbx_pkg::PH_Q4) && !flush_reg &&
    dec_reg.is_branch_on_carry_set && !carry_reg |=> !flush_reg && $stable(pc_reg)) // [RL1]
    else $error("untaken branch changed flow");

  branch_target_a: assert property ((phase_reg == cbx_pkg::PH_Q4) && taken |=>
    pc_reg == $past(pc_reg) + $past(offset2)) // [RL2]
    else $error("branch target wrong");

  pc_step_a: assert property ((phase_reg == cbx_pkg::PH_Q1) && !flush_reg |=>
    pc_reg == $past(pc_reg) + PC_W'(`CBX_PC_STEP)) // [RL3]
    else $error("pc did not advance by two");

  refill_len_a: assert property ((phase_reg == cbx_pkg::PH_Q4) && taken |=>
    NOP_CYCLE [*4] ##1 !NOP_CYCLE) // [RL4]
    else $error("refill cycle length wrong");

  refill_idle_a: assert property (NOP_CYCLE |-> // [RL4]
    (!DMEM_RD && !DMEM_WR) ##1 $stable(pc_reg))
    else $error("activity during refill cycle");

  nop_decode_a: assert property ((phase_reg == cbx_pkg::PH_Q1) && flush_reg |=> // [RL4]
    dec_reg == '0)
    else $error("instruction decoded during refill cycle");

  taken_refill_a: assert property ((phase_reg == cbx_pkg::PH_Q4) && !flush_reg && // [RL1]
    dec_reg.is_branch_on_carry_set && carry_reg |=> NOP_CYCLE)
    else $error("carry set branch not taken");

  wr_follows_rd_a: assert property (DMEM_RD |=> DMEM_WR && !DMEM_RD) // [RL5]
    else $error("write strobe does not follow read strobe");

  addr_hold_a: assert property ((phase_reg != cbx_pkg::PH_Q2) |=> // [RL6]
    $stable(DMEM_ADDR))
    else $error("data address changed outside decode phase");

  bit_cleared_a: assert property ((phase_reg == cbx_pkg::PH_Q3) &&
    dec_reg.is_clear_single_register_bit |=> DMEM_WR &&
    DMEM_WDATA == ($past(DMEM_RDATA) & ~(8'h01 << dec_reg.bit_idx))) // [RL5]
    else $error("bit clear result wrong");

  bank_select_a: assert property ((phase_reg == cbx_pkg::PH_Q2) &&
    dec_reg.is_clear_single_register_bit && dec_reg.acc |=>
    DMEM_ADDR == {$past(BSR_IN), dec_reg.lit}) // [RL7]
    else $error("banked address wrong");

  access_bank_a: assert property ((phase_reg == cbx_pkg::PH_Q2) &&
    dec_reg.is_clear_single_register_bit && !dec_reg.acc &&
    !(EXT_EN && dec_reg.lit <= `CBX_INDEX_LIMIT) |=> DMEM_ADDR[7:0] == dec_reg.lit &&
    (DMEM_ADDR[11:8] == ((dec_reg.lit < `CBX_ACCESS_SPLIT) ?
    `CBX_ACCESS_LOW_BANK : `CBX_ACCESS_HIGH_BANK))) // [RL6]
    else $error("access bank address wrong");

  indexed_mode_a: assert property ((phase_reg == cbx_pkg::PH_Q2) &&
    dec_reg.is_clear_single_register_bit && !dec_reg.acc && EXT_EN &&
    dec_reg.lit <= `CBX_INDEX_LIMIT |=>
    DMEM_ADDR == $past(INDEX_BASE) + {4'h0, dec_reg.lit}) // [RL8]
    else $error("indexed address wrong");
endmodule

//--- cbx_exec_tb.sv
// Self-checking bench for the branch and bit-clear unit
`timescale 1ns/1ns
module cbx_exec_tb;
  logic MCLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [15:0] INSTR = 16'h0000;
  logic CARRY = 1'b0;
  logic EXT_EN = 1'b0;
  logic [3:0] BSR_IN = 4'h0;
  logic [11:0] INDEX_BASE = 12'h000;
  logic [7:0] DMEM_RDATA = 8'h00;
  logic [20:0] PC_OUT;
  logic [3:0] Q_PHASE;
  logic NOP_CYCLE;
  logic DMEM_RD;
  logic DMEM_WR;
  logic [11:0] DMEM_ADDR;
  logic [7:0] DMEM_WDATA;
  logic [20:0] pc = 21'h000000;
  logic [31:0] r;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  integer seed = 32'hD7928B19;

  cbx_exec u_cbx_exec (.MCLK(MCLK), .SYS_RST(SYS_RST), .INSTR(INSTR), .CARRY(CARRY),
    .EXT_EN(EXT_EN), .BSR_IN(BSR_IN), .INDEX_BASE(INDEX_BASE), .PC_OUT(PC_OUT),
    .Q_PHASE(Q_PHASE), .NOP_CYCLE(NOP_CYCLE), .DMEM_ADDR(DMEM_ADDR), .DMEM_RD(DMEM_RD),
    .DMEM_RDATA(DMEM_RDATA), .DMEM_WR(DMEM_WR), .DMEM_WDATA(DMEM_WDATA));

  initial begin
    forever #4 MCLK = ~MCLK;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_pc(input logic [20:0] got, input logic [20:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask

  task automatic chk_mem(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask

  task automatic step;
    @(posedge MCLK);
    #1;
  endtask

  // One instruction from Q1 to the next Q1, or on a taken branch to the Q1 after the refill cycle, checked against the model
  task automatic run(input logic [15:0] w, input logic c, input logic x, input logic [3:0] b,
                     input logic [11:0] ib, input logic [7:0] rd);
    logic [11:0] ea;
    logic [20:0] tgt;
    logic bc;
    logic bcf;
    bc = (w[15:8] == 8'hE2);
    bcf = (w[15:12] == 4'h9);
    ea = w[8] ? {b, w[7:0]} : (x && w[7:0] <= 8'h5F) ? ib + {4'h0, w[7:0]} :
         (w[7:0] < 8'h60) ? {4'h0, w[7:0]} : {4'hF, w[7:0]};
    INSTR = w;
    CARRY = c;
    EXT_EN = x;
    BSR_IN = b;
    INDEX_BASE = ib;
    DMEM_RDATA = rd;
    chk_mem({8'h00, Q_PHASE}, 12'h001);
    step;
    pc = pc + 21'h000002;
    tgt = pc + {{12{w[7]}}, w[7:0], 1'b0};
    chk_pc(PC_OUT, pc);
    step;
    chk_mem({11'h000, DMEM_RD}, {11'h000, bcf});
    if (bcf) chk_mem(DMEM_ADDR, ea);
    step;
    chk_mem({11'h000, DMEM_WR}, {11'h000, bcf});
    if (bcf) chk_mem({4'h0, DMEM_WDATA}, {4'h0, rd & ~(8'h01 << w[11:9])});
    step;
    if (bc && c) pc = tgt;
    chk_pc(PC_OUT, pc);
    chk_mem({11'h000, NOP_CYCLE}, {11'h000, bc && c});
    if (bc && c) begin
      INSTR = 16'h9000;
      CARRY = ~c;
      repeat (3) begin
        step;
        chk_pc(PC_OUT, pc);
        chk_mem({9'h000, NOP_CYCLE, DMEM_RD, DMEM_WR}, 12'h004);
      end
      step;
      chk_mem({11'h000, NOP_CYCLE}, 12'h000);
      chk_pc(PC_OUT, pc);
    end
  endtask

  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      finish_test;
    end
  end

  initial begin
    repeat (10) @(posedge MCLK);
    #1;
    chk_pc(PC_OUT, 21'h000000);
    chk_mem({8'h00, Q_PHASE}, 12'h001);
    SYS_RST = 1'b0;
    run(16'hE205, 1'b0, 1'b0, 4'h0, 12'h000, 8'h00);
    run(16'hE205, 1'b1, 1'b0, 4'h0, 12'h000, 8'h00);
    run(16'hE280, 1'b1, 1'b0, 4'h0, 12'h000, 8'h00);
    run(16'h9F2A, 1'b0, 1'b1, 4'h5, 12'h300, 8'hFF);
    run(16'h9E5F, 1'b0, 1'b1, 4'h5, 12'hFF0, 8'hC7);
    run(16'h9E60, 1'b0, 1'b1, 4'h5, 12'h300, 8'hC7);
    run(16'h905F, 1'b0, 1'b0, 4'h5, 12'h300, 8'h01);
    run(16'h92FF, 1'b0, 1'b0, 4'h5, 12'h300, 8'h02);
    run(16'h1234, 1'b1, 1'b1, 4'h5, 12'h300, 8'h02);
    repeat (60) begin
      r = $random(seed);
      case (r[29:28])
        2'h0: run({8'hE2, r[7:0]}, r[16], r[17], r[23:20], r[31:20], r[15:8]);
        2'h3: run(r[15:0], r[16], r[17], r[23:20], r[31:20], r[15:8]);
        default: run({4'h9, r[11:0]}, r[16], r[17], r[23:20], r[31:20], r[27:20]);
      endcase
    end
    finish_test;
  end
endmodule

//--- cbx_pkg.sv
// Types shared by the branch and bit-clear unit
package cbx_pkg;
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } cbx_phase_t;

  typedef struct packed {
    logic is_branch_on_carry_set;
    logic is_clear_single_register_bit;
    logic [2:0] bit_idx;
    logic acc;
    logic [7:0] lit;
  } cbx_dec_t;
endpackage

//--- cbx_regs.svh
// Encoding, addressing and reset constants for the branch and bit-clear unit
`ifndef CBX_REGS_SVH
`define CBX_REGS_SVH
`define CBX_BC_OPCODE 8'hE2
`define CBX_BCF_OPCODE 4'h9
`define CBX_OP_HI_POS 15
`define CBX_BC_OP_LO_POS 8
`define CBX_BCF_OP_LO_POS 12
`define CBX_BIT_HI_POS 11
`define CBX_BIT_LO_POS 9
`define CBX_ACC_POS 8
`define CBX_LIT_HI_POS 7
`define CBX_LIT_LO_POS 0
`define CBX_INDEX_LIMIT 8'h5F
`define CBX_ACCESS_SPLIT 8'h60
`define CBX_ACCESS_LOW_BANK 4'h0
`define CBX_ACCESS_HIGH_BANK 4'hF
`define CBX_PC_STEP 2
`define CBX_PC_RESET 21'h000000
`define CBX_ADDR_RESET 12'h000
`define CBX_DATA_RESET 8'h00
`endif
